// ==== logic/dufc_consts.vh ====
// constants for the converter channel update and format control block
`ifndef DUFC_CONSTS_VH
`define DUFC_CONSTS_VH
`define DUFC_ADDR_W        2
`define DUFC_OFF_CTRL      2'h0
`define DUFC_OFF_HIGH      2'h1
`define DUFC_OFF_LOW       2'h2
`define DUFC_OFF_OUT       2'h3
`define DUFC_CTRL_RESET    8'h00
`define DUFC_DATA_RESET    8'h00
`define DUFC_CTRL_WMASK    8'h9f
`define DUFC_BIT_EN        7
`define DUFC_SRC_HI        4
`define DUFC_SRC_LO        3
`define DUFC_FMT_HI        2
`define DUFC_FMT_LO        0
`define DUFC_SRC_HWRITE    2'h0
`define DUFC_SRC_TIMER     2'h1
`define DUFC_SRC_TRIG_A    2'h2
`define DUFC_SRC_TRIG_B    2'h3
`define DUFC_FMT_4         3'h0
`define DUFC_FMT_5         3'h1
`define DUFC_FMT_6         3'h2
`define DUFC_FMT_7         3'h3
`endif

// ==== logic/dufc_top.v ====
// converter channel control: enable, update source and data word alignment
// Overview of operation
// - 8-bit control: enable, source, format rw; bits 6:5 read zero
// - enable low powers channel down, output off
// - source 00: update on high byte write
// - source 01: update on timer overflow only
// - format 000: high[3:0], low[7:0]
// - format 001: high[4:0], low[7:1]
// - format 010: high[5:0], low[7:2]
// - format 011: high[6:0], low[7:3]
// - other formats: high[7:0], low[7:4]
`timescale 1ns/10ps
`include "dufc_consts.vh"
module dufc_top #(
  parameter DATA_W = 12
) (
  input  wire                    REF_CLK,        // system clock, 125 MHz
  input  wire                    RST,            // synchronous reset, active high
  input  wire [`DUFC_ADDR_W-1:0] ADDR,           // register address
  input  wire [7:0]              WDATA,          // write data
  input  wire                    WR,             // write strobe
  input  wire                    RD,             // read strobe
  output reg  [7:0]              RDATA,          // read data, cycle after strobe
  input  wire                    TIMER_OVF,      // timer overflow pulse
  input  wire                    TRIG_A,         // further trigger for source 10
  input  wire                    TRIG_B,         // further trigger for source 11
  output reg  [DATA_W-1:0]       CONV_DATA,      // word held at converter input
  output reg                     CONV_UPDATE,    // pulse: word just transferred
  output wire                    CONV_ENABLE,    // converter output enabled
  output wire                    CONV_SHUTDOWN   // channel in low-power shutdown
);

  localparam ADDR_W = `DUFC_ADDR_W;

  // register storage and next values
  reg  [7:0]        ctrl_q;
  reg  [7:0]        ctrl_d;
  reg  [7:0]        high_q;
  reg  [7:0]        high_d;
  reg  [7:0]        low_q;
  reg  [7:0]        low_d;

  // converter side next values
  reg  [DATA_W-1:0] conv_data_d;
  reg               conv_update_d;

  // read path next value
  reg  [7:0]        rdata_d;

  // control fields
  wire              en_bit;
  wire [1:0]        src;
  wire [2:0]        fmt;

  // strobe decode
  wire              wr_ctrl;
  wire              wr_high;
  wire              wr_low;

  // update path
  wire [7:0]        high_eff;
  wire              fire;
  wire [DATA_W-1:0] word;

  // address match used by the write strobe decode only
  function dufc_hit;
    input [ADDR_W-1:0] a;
    input [ADDR_W-1:0] off;
    begin
      dufc_hit = (a == off);
    end
  endfunction

  // bits 6:5 hold no storage, so they read back as zero
  function [7:0] dufc_ctrl_mask;
    input [7:0] v;
    begin
      dufc_ctrl_mask = v & `DUFC_CTRL_WMASK;
    end
  endfunction

  // align high and low bytes into the data word
  function [11:0] dufc_align;
    input [2:0] f;
    input [7:0] h;
    input [7:0] l;
    begin
      case (f)
        `DUFC_FMT_4: begin
          dufc_align[11:8] = h[3:0];
          dufc_align[7:0]  = l[7:0];
        end
        `DUFC_FMT_5: begin
          dufc_align[11:7] = h[4:0];
          dufc_align[6:0]  = l[7:1];
        end
        `DUFC_FMT_6: begin
          dufc_align[11:6] = h[5:0];
          dufc_align[5:0]  = l[7:2];
        end
        `DUFC_FMT_7: begin
          dufc_align[11:5] = h[6:0];
          dufc_align[4:0]  = l[7:3];
        end
        default: begin
          dufc_align[11:4] = h[7:0];
          dufc_align[3:0]  = l[7:4];
        end
      endcase
    end
  endfunction

  // one selected event moves the word; the others are ignored
  function dufc_pick;
    input [1:0] s;
    input       hw;
    input       tm;
    input       ta;
    input       tb;
    begin
      case (s)
        `DUFC_SRC_HWRITE: begin
          dufc_pick = hw;
        end
        `DUFC_SRC_TIMER: begin
          dufc_pick = tm;
        end
        `DUFC_SRC_TRIG_A: begin
          dufc_pick = ta;
        end
        `DUFC_SRC_TRIG_B: begin
          dufc_pick = tb;
        end
        default: begin
          dufc_pick = 1'b0;
        end
      endcase
    end
  endfunction

  // read mux; the last offset shows the low byte of the held word
  function [7:0] dufc_read;
    input [ADDR_W-1:0] a;
    input [7:0]        c;
    input [7:0]        h;
    input [7:0]        l;
    input [7:0]        o;
    begin
      case (a)
        `DUFC_OFF_CTRL: begin
          dufc_read = c;
        end
        `DUFC_OFF_HIGH: begin
          dufc_read = h;
        end
        `DUFC_OFF_LOW: begin
          dufc_read = l;
        end
        default: begin
          dufc_read = o;
        end
      endcase
    end
  endfunction

  assign en_bit   = ctrl_q[`DUFC_BIT_EN];
  assign src      = ctrl_q[`DUFC_SRC_HI:`DUFC_SRC_LO];
  assign fmt      = ctrl_q[`DUFC_FMT_HI:`DUFC_FMT_LO];

  // writes to the read-only offset decode to nothing
  assign wr_ctrl  = WR && dufc_hit(ADDR, `DUFC_OFF_CTRL);
  assign wr_high  = WR && dufc_hit(ADDR, `DUFC_OFF_HIGH);
  assign wr_low   = WR && dufc_hit(ADDR, `DUFC_OFF_LOW);

  // word uses the freshly written high byte so the update sees it
  assign high_eff = wr_high ? WDATA : high_q;
  assign word     = dufc_align(fmt, high_eff, low_q);

  assign fire     = dufc_pick(src, wr_high, TIMER_OVF, TRIG_A, TRIG_B);

  assign CONV_ENABLE   = en_bit;
  assign CONV_SHUTDOWN = ~en_bit;

  // register file next state
  always @* begin
    ctrl_d = ctrl_q;
    high_d = high_q;
    low_d  = low_q;
    if (wr_ctrl) begin
      ctrl_d = dufc_ctrl_mask(WDATA);
    end
    if (wr_high) begin
      high_d = WDATA;
    end
    if (wr_low) begin
      low_d = WDATA;
    end
  end

  always @(posedge REF_CLK) begin
    if (RST) begin
      ctrl_q <= `DUFC_CTRL_RESET;
      high_q <= `DUFC_DATA_RESET;
      low_q  <= `DUFC_DATA_RESET;
    end else begin
      ctrl_q <= ctrl_d;
      high_q <= high_d;
      low_q  <= low_d;
    end
  end

  // word still loads while shut down so output is current on enable
  always @* begin
    conv_data_d   = CONV_DATA;
    conv_update_d = fire;
    if (fire) begin
      conv_data_d = word;
    end
  end

  always @(posedge REF_CLK) begin
    if (RST) begin
      CONV_DATA   <= {DATA_W{1'b0}};
      CONV_UPDATE <= 1'b0;
    end else begin
      CONV_DATA   <= conv_data_d;
      CONV_UPDATE <= conv_update_d;
    end
  end

  // read data stands in each cycle after a cycle with the strobe high, zero otherwise
  always @* begin
    rdata_d = 8'h00;
    if (RD) begin
      rdata_d = dufc_read(ADDR, ctrl_q, high_q, low_q, CONV_DATA[7:0]);
    end
  end

  always @(posedge REF_CLK) begin
    if (RST) begin
      RDATA <= 8'h00;
    end else begin
      RDATA <= rdata_d;
    end
  end

endmodule // dufc_top

// ==== tb/dufc_sva.sv ====
// control block checker
`timescale 1ns/10ps
module dufc_sva(input wire REF_CLK,RST,WR,RD,TIMER_OVF,TRIG_A,TRIG_B,
  input wire [1:0] ADDR,input wire [7:0] WDATA,RDATA,
  input wire CONV_UPDATE,CONV_ENABLE,CONV_SHUTDOWN);
  reg [7:0] c_q;
  wire [1:0] s=c_q[4:3];
  wire cw=WR&&ADDR==2'h0;
  always @(posedge REF_CLK) c_q<=RST?8'h00:cw?WDATA&8'h9f:c_q;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  property p_pw; CONV_ENABLE^CONV_SHUTDOWN; endproperty
  a_pw: assert property(p_pw) else $error("power");
  property p_en; cw|=>CONV_ENABLE==$past(WDATA[7]); endproperty
  a_en: assert property(p_en) else $error("enable");
  property p_rd; RD&&ADDR==2'h0|=>RDATA==c_q; endproperty
  a_rd: assert property(p_rd) else $error("control");
  property p_wr; WR&&ADDR==2'h1&&s==2'h0|=>CONV_UPDATE; endproperty
  a_wr: assert property(p_wr) else $error("write");
  property p_tm; TIMER_OVF&&s==2'h1|=>CONV_UPDATE; endproperty
  a_tm: assert property(p_tm) else $error("timer");
  property p_ta; TRIG_A&&s==2'h2|=>CONV_UPDATE; endproperty
  a_ta: assert property(p_ta) else $error("trig");
  property p_tb; TRIG_B&&s==2'h3|=>CONV_UPDATE; endproperty
  a_tb: assert property(p_tb) else $error("trig");
  property p_up; CONV_UPDATE|->$past(WR||TIMER_OVF||TRIG_A||TRIG_B); endproperty
  a_up: assert property(p_up) else $error("update");
  cover property(CONV_UPDATE);
  cover property(cw);
  cover property(RD);
endmodule // dufc_sva

// ==== tb/dufc_top_tb.sv ====
// bench for the converter channel control block
`timescale 1ns/10ps
module dufc_top_tb;
  reg         REF_CLK = 1'b0;
  reg         RST     = 1'b1;
  reg         WR      = 1'b0;
  reg         RD      = 1'b0;
  reg  [1:0]  ADDR    = 2'h0;
  reg  [7:0]  WDATA   = 8'h00;
  reg  [2:0]  trg     = 3'h0;
  reg  [7:0]  h;
  reg  [7:0]  l;
  reg  [7:0]  cv;
  reg  [11:0] e;
  integer     errors  = 0;
  integer     checked = 0;
  integer     n       = 0;
  integer     i;
  integer     seed;
  wire        TIMER_OVF = trg[0];
  wire        TRIG_A    = trg[1];
  wire        TRIG_B    = trg[2];
  wire        CONV_UPDATE;
  wire        CONV_ENABLE;
  wire        CONV_SHUTDOWN;
  wire [7:0]  RDATA;
  wire [11:0] CONV_DATA;

  always #4 REF_CLK = ~REF_CLK;

  dufc_top i_dut (
    .REF_CLK       (REF_CLK),
    .RST           (RST),
    .ADDR          (ADDR),
    .WDATA         (WDATA),
    .WR            (WR),
    .RD            (RD),
    .RDATA         (RDATA),
    .TIMER_OVF     (TIMER_OVF),
    .TRIG_A        (TRIG_A),
    .TRIG_B        (TRIG_B),
    .CONV_DATA     (CONV_DATA),
    .CONV_UPDATE   (CONV_UPDATE),
    .CONV_ENABLE   (CONV_ENABLE),
    .CONV_SHUTDOWN (CONV_SHUTDOWN)
  );

  // expected word straight from the format table
  function [11:0] exp_word(input [2:0] f, input [7:0] hb, input [7:0] lb);
    case (f)
      3'h0:    exp_word = {hb[3:0], lb};
      3'h1:    exp_word = {hb[4:0], lb[7:1]};
      3'h2:    exp_word = {hb[5:0], lb[7:2]};
      3'h3:    exp_word = {hb[6:0], lb[7:3]};
      default: exp_word = {hb, lb[7:4]};
    endcase
  endfunction

  task cmp_word(input [11:0] got, input [11:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("mismatch word exp %h got %h", exp, got);
      end
    end
  endtask

  task cmp_byte(input [7:0] got, input [7:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("mismatch rdata exp %h got %h", exp, got);
      end
    end
  endtask

  task cmp_bit(input string nm, input got, input exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("mismatch %s exp %b got %b", nm, exp, got);
      end
    end
  endtask

  task wr(input [1:0] a, input [7:0] v);
    begin
      @(posedge REF_CLK);
      WR    <= 1'b1;
      ADDR  <= a;
      WDATA <= v;
      @(posedge REF_CLK);
      WR    <= 1'b0;
      #1;
    end
  endtask

  // read data stands in the cycle after the strobe, checked there
  task rd(input [1:0] a);
    begin
      @(posedge REF_CLK);
      RD   <= 1'b1;
      ADDR <= a;
      @(posedge REF_CLK);
      RD   <= 1'b0;
      #1;
    end
  endtask

  task pulse(input [2:0] m);
    begin
      @(posedge REF_CLK);
      trg <= m;
      @(posedge REF_CLK);
      trg <= 3'h0;
      #1;
    end
  endtask

  task results;
    begin
      $display("errors %0d checked %0d", errors, checked);
      if (errors == 0 && checked > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask

  // ceiling well above the fewer than two hundred cycles the tests need
  always @(posedge REF_CLK) begin
    n = n + 1;
    if (n > 3000) begin
      errors = errors + 1;
      results;
    end
  end

  initial begin
    seed = $urandom(57);
    repeat (12) @(posedge REF_CLK);
    RST <= 1'b0;
    #1;
    cmp_bit("enable", CONV_ENABLE, 1'b0);
    cmp_bit("shutdown", CONV_SHUTDOWN, 1'b1);
    rd(2'h0);
    cmp_byte(RDATA, 8'h00);
    wr(2'h0, 8'hff);
    cmp_bit("enable", CONV_ENABLE, 1'b1);
    cmp_bit("shutdown", CONV_SHUTDOWN, 1'b0);
    rd(2'h0);
    cmp_byte(RDATA, 8'h9f);
    @(posedge REF_CLK);
    #1;
    cmp_byte(RDATA, 8'h00);
    e = 12'h000;
    for (i = 0; i < 11; i = i + 1) begin
      h = $urandom;
      l = $urandom;
      cv[7]   = $urandom;
      cv[6:5] = 2'b00;
      cv[4:3] = (i < 8) ? 2'h0 : i[1:0] + 2'h1;
      cv[2:0] = (i < 8) ? i[2:0] : $urandom;
      wr(2'h0, cv | 8'h60);
      cmp_bit("enable", CONV_ENABLE, cv[7]);
      cmp_bit("shutdown", CONV_SHUTDOWN, ~cv[7]);
      rd(2'h0);
      cmp_byte(RDATA, cv);
      wr(2'h2, l);
      wr(2'h1, h);
      if (i < 8) begin
        e = exp_word(cv[2:0], h, l);
        cmp_bit("update", CONV_UPDATE, 1'b1);
        cmp_word(CONV_DATA, e);
      end else begin
        cmp_bit("update", CONV_UPDATE, 1'b0);
        cmp_word(CONV_DATA, e);
        pulse(~(3'h1 << i[1:0]));
        cmp_bit("update", CONV_UPDATE, 1'b0);
        cmp_word(CONV_DATA, e);
        e = exp_word(cv[2:0], h, l);
        pulse(3'h1 << i[1:0]);
        cmp_bit("update", CONV_UPDATE, 1'b1);
        cmp_word(CONV_DATA, e);
      end
      rd(2'h1);
      cmp_byte(RDATA, h);
      rd(2'h2);
      cmp_byte(RDATA, l);
    end
    rd(2'h3);
    cmp_byte(RDATA, e[7:0]);
    wr(2'h0, 8'h00);
    cmp_bit("shutdown", CONV_SHUTDOWN, 1'b1);
    results;
  end
endmodule // dufc_top_tb
bind dufc_top dufc_sva i_sva (
  .REF_CLK       (REF_CLK),
  .RST           (RST),
  .WR            (WR),
  .RD            (RD),
  .TIMER_OVF     (TIMER_OVF),
  .TRIG_A        (TRIG_A),
  .TRIG_B        (TRIG_B),
  .ADDR          (ADDR),
  .WDATA         (WDATA),
  .RDATA         (RDATA),
  .CONV_UPDATE   (CONV_UPDATE),
  .CONV_ENABLE   (CONV_ENABLE),
  .CONV_SHUTDOWN (CONV_SHUTDOWN)
);
